// *** pkg/nv_ctrl_pkg.sv ***
package nv_ctrl_pkg;

  // ----------------------------------------
  // register map, I/O-style byte offsets
  // ----------------------------------------
  localparam logic [1:0] OFS_CONTROL = 2'h0;
  localparam logic [1:0] OFS_DATA = 2'h1;
  localparam logic [1:0] OFS_ADDR_LOW = 2'h2;
  localparam logic [1:0] OFS_ADDR_HIGH = 2'h3;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int BIT_READ = 0;
  localparam int BIT_GO = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_RDY_IE = 3;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_MODE_HI = 5;

  localparam int ADDR_W = 9;
  localparam int ARRAY_BYTES = 512;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] ARM_CYCLES = 3'h4;

  // ----------------------------------------
  // programming modes and timing
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE = 2'h1,
    MODE_WRITE = 2'h2,
    MODE_RSVD = 2'h3
  } prog_mode_e;

  localparam int ATOMIC_TIME_US = 3400;
  localparam int SPLIT_TIME_US = 1800;
  localparam int OSC_KHZ = 8000;
  localparam int ATOMIC_TICKS = ATOMIC_TIME_US * OSC_KHZ / 1000;
  localparam int SPLIT_TICKS = SPLIT_TIME_US * OSC_KHZ / 1000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] ofs;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : nv_ctrl_pkg

// *** core/nv_byte_ctrl.sv ***
`timescale 1ns/1ps
// Operation
// R1: mode 00 plus armed go bit starts erase then write of addressed byte
// R2: go bit reads set until both erase and write phases are done
// R3: during programming every other operation, read or program, is ignored
// R4: mode 01 armed go erases addressed byte; busy until erase done
// R5: mode 10 armed go writes data byte without erase; busy until done
// R6: software must erase before a write-only; else stored value undefined
// R7: programming duration counted on calibrated oscillator ticks, not system clock
// R8: reset during programming does not abort the operation
// R9: address is nine bits; high register bit 0 is bit 8, rest zero
// R10: address has no reset value; software loads it before access
// R11: addresses map linearly onto array bytes from zero
// R12: write and atomic store current data byte at addressed location
// R13: read loads data register from addressed byte; data resets to zero
// R14: software loads address and data, sets arm, then sets go
// R15: arm self-clears after four cycles; go without arm does nothing
// R16: mode field writes ignored while go bit is set
// R17: atomic 3.4ms, split modes 1.8ms each; mode 11 reserved
// R18: read strobe reads; reads and address writes blocked while busy
// R19: ready output high whenever go bit is clear; ready_q is the inverse of go_q one cycle late and is held low during reset
module nv_byte_ctrl #(
  parameter int ATOMIC_T = nv_ctrl_pkg::ATOMIC_TICKS, // atomic duration in osc ticks
  parameter int SPLIT_T = nv_ctrl_pkg::SPLIT_TICKS // split duration in osc ticks
) (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic reset_n, // async reset, active low
  input wire nv_ctrl_pkg::reg_req_s req, // register access
  input wire logic osc_tick, // calibrated oscillator tick, async
  output logic [7:0] rdata_q, // register read data
  output logic busy_q, // programming in progress
  output logic ready_q, // new operation may start
  output logic rdy_irq_q // ready and ready-enable set
);
  import nv_ctrl_pkg::*;

  // ----------------------------------------
  // storage and registers
  // ----------------------------------------
  logic [7:0] mem_q [ARRAY_BYTES];
  logic [ADDR_W-1:0] addr_q; // no reset value [R10]
  logic [7:0] data_q;
  logic [1:0] mode_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;
  logic go_q;
  logic rdy_ie_q;
  logic [1:0] op_mode_q;
  logic [31:0] tick_cnt_q;
  logic [2:0] tick_sync_q;
  logic tick_seen_q;
  logic tick_pulse;
  logic [31:0] op_len;

  wire wr_ctl = req.wr && req.ofs == OFS_CONTROL;
  wire start = wr_ctl && req.wdata[BIT_GO] && arm_q && !go_q
    && prog_mode_e'(mode_q) != MODE_RSVD; // [R1] [R15] [R17]
  wire rd_go = wr_ctl && req.wdata[BIT_READ]
    && !go_q; // [R18] [R3]

  // ----------------------------------------
  // oscillator tick sampling
  // ----------------------------------------
  // osc is asynchronous: three flops, count a rise when last two agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_sync_q <= 3'h0;
    end else begin
      tick_sync_q <= {tick_sync_q[1:0], osc_tick};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_seen_q <= 1'b0;
    end else if (tick_sync_q[2] == tick_sync_q[1]) begin
      tick_seen_q <= tick_sync_q[2];
    end
  end
  assign tick_pulse = tick_sync_q[2] == tick_sync_q[1] && tick_sync_q[2] && !tick_seen_q; // [R7]

  // ----------------------------------------
  // address and data registers
  // ----------------------------------------
  // address held across reset: it has no defined reset value
  always_ff @(posedge clk_sys) begin
    if (req.wr && !go_q && req.ofs == OFS_ADDR_LOW) begin // [R18]
      addr_q[7:0] <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (req.wr && !go_q && req.ofs == OFS_ADDR_HIGH) begin // [R9]
      addr_q[8] <= req.wdata[0];
    end
  end

  // refused writes leave the value a running program uses
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= DATA_RESET; // [R13]
    end else if (rd_go) begin
      data_q <= mem_q[addr_q]; // [R13] [R11]
    end else if (req.wr && req.ofs == OFS_DATA && !go_q) begin
      data_q <= req.wdata;
    end
  end

  // ----------------------------------------
  // arm window and ready-enable bit
  // ----------------------------------------
  // arm window restarts on every arm write unless that same write starts a program; an accepted go ends it early
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else begin
      if (wr_ctl && req.wdata[BIT_ARM] && !start) begin
        arm_q <= 1'b1;
        arm_cnt_q <= ARM_CYCLES;
      end else if (start || arm_cnt_q == 3'h1) begin
        arm_q <= 1'b0; // [R15]
        arm_cnt_q <= 3'h0;
      end else if (arm_cnt_q != 3'h0) begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdy_ie_q <= 1'b0;
    end else if (wr_ctl) begin
      rdy_ie_q <= req.wdata[BIT_RDY_IE];
    end
  end

  // ----------------------------------------
  // programming engine
  // ----------------------------------------
  // engine holds no reset so a running operation finishes through reset
  logic go_init_q = 1'b0;
  always_comb begin
    if (prog_mode_e'(op_mode_q) == MODE_ATOMIC) begin
      op_len = ATOMIC_T; // [R17]
    end else begin
      op_len = SPLIT_T;
    end
  end

  always_ff @(posedge clk_sys) begin // [R8]
    if (!go_init_q) begin
      go_init_q <= 1'b1;
      go_q <= 1'b0;
      mode_q <= 2'h0;
    end else if (start) begin
      go_q <= 1'b1;
      op_mode_q <= mode_q;
      tick_cnt_q <= 32'h0;
    end else if (go_q) begin
      if (tick_pulse) begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
      if (tick_cnt_q >= op_len) begin
        go_q <= 1'b0; // [R2] [R4] [R5]
        case (prog_mode_e'(op_mode_q))
          MODE_ERASE: mem_q[addr_q] <= ERASED_BYTE; // [R4]
          MODE_WRITE: mem_q[addr_q] <= mem_q[addr_q] & data_q; // [R5] [R6]
          default: mem_q[addr_q] <= data_q; // [R12]
        endcase
      end
    end else if (!reset_n) begin
      mode_q <= 2'h0;
    end else if (wr_ctl) begin
      mode_q <= req.wdata[BIT_MODE_HI:BIT_MODE_LO]; // [R16]
    end
  end

  // ----------------------------------------
  // read back and status
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= go_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= !go_q; // [R19]
    end
  end

  // level, not pulse: stays up while the array is idle and ready-enable is set
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdy_irq_q <= 1'b0;
    end else begin
      rdy_irq_q <= !go_q && rdy_ie_q;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      if (req.ofs == OFS_CONTROL) begin
        rdata_q <= {2'h0, mode_q, rdy_ie_q, arm_q, go_q, 1'b0};
      end else if (req.ofs == OFS_DATA) begin
        rdata_q <= data_q;
      end else if (req.ofs == OFS_ADDR_LOW) begin
        rdata_q <= addr_q[7:0];
      end else begin
        rdata_q <= {7'h00, addr_q[8]}; // [R9]
      end
    end
  end

endmodule : nv_byte_ctrl

// *** tb/nv_byte_ctrl_checker.sv ***
`timescale 1ns/1ps
module nv_byte_ctrl_checker
  import nv_ctrl_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset
  input wire nv_ctrl_pkg::reg_req_s req, // access
  input wire logic osc_tick, // osc ticks
  input wire logic [7:0] rdata_q, // read data
  input wire logic busy_q, // busy
  input wire logic ready_q, // ready
  input wire logic rdy_irq_q // ready irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire ctl_w = req.wr && req.ofs == OFS_CONTROL;
  wire arm_w = ctl_w && req.wdata[BIT_ARM];
  wire go_w = ctl_w && req.wdata[BIT_GO];
  // start seen only with reset long gone, so a resumed run is not mistaken for one
  sequence s_busy_start;
    (!busy_q && $past(reset_n) && $past(reset_n, 2)) ##1 busy_q;
  endsequence
  a_ready_inv: assert property ($past(reset_n) |-> ready_q == !busy_q) else $error("ready not inverse of busy");
  a_irq_ready: assert property (rdy_irq_q |-> ready_q) else $error("irq while not ready");
  a_go_cause: assert property (s_busy_start |-> $past(go_w, 2)) else $error("busy without go write");
  property p_arm_window;
    s_busy_start |-> $past(arm_w, 3) || $past(arm_w, 4) || $past(arm_w, 5) || $past(arm_w, 6);
  endproperty
  a_arm_window: assert property (p_arm_window) else $error("busy without arm in window");
  a_busy_min: assert property (s_busy_start |-> busy_q [*8]) else $error("busy too short");
  a_busy_bound: assert property (s_busy_start |-> ##[1:400] !busy_q) else $error("busy never ends");
  a_rdata_hold: assert property ($past(reset_n) && !$past(req.rd) |-> $stable(rdata_q)) else $error("rdata moved");
  a_rdata_reset: assert property ($rose(reset_n) |-> rdata_q == DATA_RESET) else $error("rdata not reset");
endmodule : nv_byte_ctrl_checker

bind nv_byte_ctrl nv_byte_ctrl_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .osc_tick(osc_tick),
  .rdata_q(rdata_q), .busy_q(busy_q), .ready_q(ready_q), .rdy_irq_q(rdy_irq_q));

// *** tb/eeprom_byte_access_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module eeprom_byte_access_ctrl_tb_top;
  import nv_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic osc_tick = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata_q;
  logic busy_q, ready_q, rdy_irq_q;
  int n_fail = 0, n_compared = 0, cyc = 0;
  // short counts keep the run small
  nv_byte_ctrl #(.ATOMIC_T(5), .SPLIT_T(3)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
    .osc_tick(osc_tick), .rdata_q(rdata_q), .busy_q(busy_q), .ready_q(ready_q), .rdy_irq_q(rdy_irq_q));
  always #12.5 clk_sys = ~clk_sys;
  always #100 osc_tick = ~osc_tick;
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [1:0] o, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, ofs: o, wdata: d};
    @(posedge clk_sys);
    #2;
    req.wr = 1'b0;
    @(posedge clk_sys);
    #2;
  endtask : wr
  task automatic rd(input string nm, input logic [1:0] o, input logic [7:0] e);
    req.rd = 1'b1;
    req.ofs = o;
    @(posedge clk_sys);
    #2;
    req.rd = 1'b0;
    @(posedge clk_sys);
    #2;
    chk(nm, e, rdata_q);
  endtask : rd
  task automatic idle;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 400 && busy_q !== 1'b0; i++) @(posedge clk_sys);
    #2;
  endtask : idle
  task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m, input logic [7:0] e, input bit hit);
    wr(OFS_ADDR_LOW, a[7:0]);
    wr(OFS_ADDR_HIGH, {7'h00, a[8]});
    wr(OFS_DATA, d);
    wr(OFS_CONTROL, {2'h0, m, 4'h0});
    wr(OFS_CONTROL, {2'h0, m, 4'h4});
    wr(OFS_CONTROL, {2'h0, m, 4'h2});
    if (hit) begin
      // all of these must bounce off a running program
      wr(OFS_DATA, 8'h00);
      wr(OFS_ADDR_LOW, 8'h00);
      wr(OFS_CONTROL, 8'h11);
      rd("ctl busy", OFS_CONTROL, 8'h02);
    end
    idle();
    wr(OFS_CONTROL, {2'h0, m, 4'h1});
    rd("data", OFS_DATA, e);
  endtask : prog
  initial begin
    repeat (6) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    rd("data rst", OFS_DATA, DATA_RESET);
    wr(OFS_ADDR_HIGH, 8'hFF);
    rd("addr hi", OFS_ADDR_HIGH, 8'h01);
    $display("test reset done");
    prog(9'h1A5, 8'h3C, MODE_ATOMIC, 8'h3C, 1'b1);
    prog(9'h1A5, 8'h00, MODE_ERASE, ERASED_BYTE, 1'b0);
    prog(9'h1A5, 8'h5A, MODE_WRITE, 8'h5A, 1'b0);
    prog(9'h0A5, 8'h66, MODE_ATOMIC, 8'h66, 1'b0);
    $display("test program done");
    wr(OFS_CONTROL, 8'h02);
    wr(OFS_CONTROL, 8'h34);
    wr(OFS_CONTROL, 8'h32);
    repeat (3) @(posedge clk_sys);
    #2;
    chk("busy", 8'h00, {7'h00, busy_q});
    chk("ready", 8'h01, {7'h00, ready_q});
    $display("test refuse done");
    wr(OFS_CONTROL, 8'h10);
    wr(OFS_CONTROL, 8'h14);
    wr(OFS_CONTROL, 8'h12);
    repeat (4) @(posedge clk_sys);
    #2;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    idle();
    wr(OFS_CONTROL, 8'h01);
    rd("erase after reset", OFS_DATA, ERASED_BYTE);
    wr(OFS_CONTROL, 8'h08);
    @(posedge clk_sys);
    #2;
    chk("irq", 8'h01, {7'h00, rdy_irq_q});
    $display("test reset mid done");
    final_report();
  end
endmodule : eeprom_byte_access_ctrl_tb_top
